//--- rtl/etd_channel.sv
`timescale 1ns/1ps
// Contract
// - Activation enable bit gates its source; hardware clears it at transfer end; in repeat mode the code clears it only if repeat interrupt enable is set.
// - Destination fixed or incremented per unit; ignored when destination is repeat area.
// - Source fixed or incremented per unit; ignored when source is repeat area.
// - Mode bit selects normal or repeat; repeat-area select chooses destination or source.
// - Repeat interrupt enable raises interrupt at repeat-cycle end; no effect in normal mode.
// - Size bit picks 8 or 16 bit units; block size 00H means 256 units.
// - Transfer count gives transfers to perform; 00H means 256.
// - Separate 16-bit source and destination registers; read source, write destination.
module etd_channel
(
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output etd_pkg::etd_apb_rsp_s    apb_rsp,
    input  wire logic [7:0]          act_events,
    output etd_pkg::etd_mem_req_s    mem_req,
    input  wire logic                mem_ack,
    input  wire logic [15:0]         mem_rdata,
    output logic                     irq
);
    import etd_pkg::*;

    etd_regs_s r;
    etd_regs_s next_r;

    function automatic logic [7:0] lowest_bit(input logic [7:0] v);
        lowest_bit = v & (~v + 8'h01);
    endfunction : lowest_bit

    function automatic logic [2:0] bit_index(input logic [7:0] onehot);
        bit_index = 3'd0;
        for (int i = 0; i < 8; i++)
        begin
            if (onehot[i])
            begin
                bit_index = 3'(i);
            end
        end
    endfunction : bit_index

    logic [7:0]  pending;
    logic [7:0]  pick;
    logic        apb_access;
    logic        apb_wr;
    logic [31:0] rd_word;
    logic        mapped;
    logic        wide;
    logic        repeat_mode;
    logic        src_step;
    logic        dst_step;
    logic [15:0] step;
    logic        last_transfer;

    always_comb
    begin
        next_r = r;
        pending = act_events & r.act_enable;
        pick = lowest_bit(pending);
        apb_access = psel && penable && !r.apb.pready;
        apb_wr = apb_access && pwrite;
        wide = r.control[CTL_SIZE16];
        repeat_mode = r.control[CTL_MODE];
        src_step = r.control[CTL_SRCINC] && !(repeat_mode && r.control[CTL_REPEAT_AREA_SELECT]);
        dst_step = r.control[CTL_DSTINC] && !(repeat_mode && !r.control[CTL_REPEAT_AREA_SELECT]);
        step = wide ? ADDR_TWO : ADDR_ONE;
        last_transfer = (r.count == CNT_ONE);
        mapped = 1'b1;
        rd_word = SLV_ERR_DATA;
        case (paddr)
            OFS_ACT_ENABLE: rd_word[7:0] = r.act_enable;
            OFS_CTRL_BASE:  rd_word[7:0] = r.ctrl_base;
            OFS_CONTROL:    rd_word[7:0] = r.control;
            OFS_BLOCK_SIZE: rd_word[7:0] = r.block_size;
            OFS_COUNT:      rd_word[7:0] = r.count;
            OFS_RELOAD:     rd_word[7:0] = r.reload;
            OFS_SRC_ADDR:   rd_word[15:0] = r.src_addr;
            OFS_DST_ADDR:   rd_word[15:0] = r.dst_addr;
            OFS_IRQ_STATUS: rd_word[1:0] = r.irq_status;
            OFS_IRQ_MASK:   rd_word[1:0] = r.irq_mask;
            OFS_BUSY:       rd_word[0] = (r.state != ST_IDLE);
            default:        mapped = 1'b0;
        endcase

        // One wait state: the answer comes in the cycle after the access phase begins.
        next_r.apb.pready = apb_access;
        next_r.apb.pslverr = apb_access && !mapped;
        next_r.apb.prdata = (apb_access && !pwrite) ? rd_word : SLV_ERR_DATA;

        if (apb_wr)
        begin
            case (paddr)
                OFS_ACT_ENABLE: next_r.act_enable = pwdata[7:0];
                OFS_CTRL_BASE:  next_r.ctrl_base = pwdata[7:0];
                OFS_CONTROL:    next_r.control = {1'b0, pwdata[6:0]};
                OFS_BLOCK_SIZE: next_r.block_size = pwdata[7:0];
                OFS_COUNT:      next_r.count = pwdata[7:0];
                OFS_RELOAD:     next_r.reload = pwdata[7:0];
                OFS_SRC_ADDR:   next_r.src_addr = pwdata[15:0];
                OFS_DST_ADDR:   next_r.dst_addr = pwdata[15:0];
                OFS_IRQ_STATUS: next_r.irq_status = r.irq_status & ~pwdata[1:0];
                OFS_IRQ_MASK:   next_r.irq_mask = pwdata[1:0];
                default:        next_r.data = r.data;
            endcase
        end

        case (r.state)
            ST_IDLE:
            begin
                if (pending != 8'h00)
                begin
                    // Fetch of the activated source's control entry, one byte per source.
                    next_r.src_sel = bit_index(pick);
                    next_r.mem.req = 1'b1;
                    next_r.mem.wr = 1'b0;
                    next_r.mem.wide = 1'b0;
                    next_r.mem.addr = {r.ctrl_base, 5'h00, bit_index(pick)};
                    next_r.rpt_src = r.src_addr;
                    next_r.rpt_dst = r.dst_addr;
                    next_r.units_left = (r.block_size == 8'h00) ? 9'h100 : {1'b0, r.block_size};
                    next_r.state = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                if (mem_ack)
                begin
                    next_r.mem.req = 1'b1;
                    next_r.mem.wide = wide;
                    next_r.mem.addr = r.src_addr;
                    next_r.state = ST_READ;
                end
            end
            ST_READ:
            begin
                if (mem_ack)
                begin
                    next_r.data = wide ? mem_rdata : {8'h00, mem_rdata[7:0]};
                    next_r.mem.wr = 1'b1;
                    next_r.mem.addr = r.dst_addr;
                    next_r.mem.wdata = wide ? mem_rdata : {8'h00, mem_rdata[7:0]};
                    next_r.state = ST_WRITE;
                end
            end
            ST_WRITE:
            begin
                if (mem_ack)
                begin
                    next_r.src_addr = src_step ? r.src_addr + step : r.src_addr;
                    next_r.dst_addr = dst_step ? r.dst_addr + step : r.dst_addr;
                    next_r.units_left = r.units_left - 9'h001;
                    next_r.mem.wr = 1'b0;
                    next_r.mem.addr = src_step ? r.src_addr + step : r.src_addr;
                    if (r.units_left == 9'h001)
                    begin
                        next_r.mem.req = 1'b0;
                        next_r.state = ST_IDLE;
                        next_r.count = r.count - CNT_ONE;
                        if (last_transfer)
                        begin
                            if (repeat_mode)
                            begin
                                next_r.count = r.reload;
                                if (r.control[CTL_REPEAT_AREA_SELECT])
                                begin
                                    next_r.src_addr = r.rpt_src;
                                end
                                else
                                begin
                                    next_r.dst_addr = r.rpt_dst;
                                end
                                if (r.control[CTL_REPEAT_INTERRUPT_ENABLE])
                                begin
                                    next_r.irq_status[IRQ_REPEAT] = 1'b1;
                                    next_r.act_enable[r.src_sel] = 1'b0;
                                end
                            end
                            else
                            begin
                                next_r.irq_status[IRQ_END] = 1'b1;
                                next_r.act_enable[r.src_sel] = 1'b0;
                            end
                        end
                    end
                    else
                    begin
                        next_r.state = ST_READ;
                    end
                end
            end
            default:
            begin
                next_r.state = ST_IDLE;
                next_r.mem.req = 1'b0;
            end
        endcase

        next_r.irq = |(next_r.irq_status & r.irq_mask);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            r <= '0;
            r.state <= ST_IDLE;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign apb_rsp = r.apb;
    assign mem_req = r.mem;
    assign irq = r.irq;

endmodule : etd_channel

//--- rtl/etd_pkg.sv
package etd_pkg;

    // Register offsets (byte addresses on the APB).
    localparam logic [7:0] OFS_ACT_ENABLE = 8'h00;
    localparam logic [7:0] OFS_CTRL_BASE  = 8'h04;
    localparam logic [7:0] OFS_CONTROL    = 8'h08;
    localparam logic [7:0] OFS_BLOCK_SIZE = 8'h0C;
    localparam logic [7:0] OFS_COUNT      = 8'h10;
    localparam logic [7:0] OFS_RELOAD     = 8'h14;
    localparam logic [7:0] OFS_SRC_ADDR   = 8'h18;
    localparam logic [7:0] OFS_DST_ADDR   = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h24;
    localparam logic [7:0] OFS_BUSY       = 8'h28;

    // Control register field positions.
    localparam int CTL_MODE    = 0;
    localparam int CTL_REPEAT_AREA_SELECT  = 1;
    localparam int CTL_SRCINC  = 2;
    localparam int CTL_DSTINC  = 3;
    localparam int CTL_CHAIN   = 4;
    localparam int CTL_REPEAT_INTERRUPT_ENABLE  = 5;
    localparam int CTL_SIZE16  = 6;

    // Interrupt status bit positions.
    localparam int IRQ_END     = 0;
    localparam int IRQ_REPEAT  = 1;

    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0]  CNT_ONE  = 8'h01;
    localparam logic [15:0] ADDR_ONE = 16'h0001;
    localparam logic [15:0] ADDR_TWO = 16'h0002;
    localparam logic [31:0] SLV_ERR_DATA = 32'h0000_0000;

    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_READ  = 4'b0100,
        ST_WRITE = 4'b1000
    } etd_state_e;

    typedef struct packed
    {
        logic        req;
        logic        wr;
        logic        wide;
        logic [15:0] addr;
        logic [15:0] wdata;
    } etd_mem_req_s;

    typedef struct packed
    {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } etd_apb_rsp_s;

    typedef struct packed
    {
        etd_state_e   state;
        logic [7:0]   act_enable;
        logic [7:0]   ctrl_base;
        logic [7:0]   control;
        logic [7:0]   block_size;
        logic [7:0]   count;
        logic [7:0]   reload;
        logic [15:0]  src_addr;
        logic [15:0]  dst_addr;
        logic [15:0]  rpt_src;
        logic [15:0]  rpt_dst;
        logic [1:0]   irq_status;
        logic [1:0]   irq_mask;
        logic [2:0]   src_sel;
        logic [8:0]   units_left;
        logic [15:0]  data;
        etd_mem_req_s mem;
        etd_apb_rsp_s apb;
        logic         irq;
    } etd_regs_s;

endpackage : etd_pkg

//--- tb/etd_mem_model.sv
`timescale 1ns/1ps
module etd_mem_model
(
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             slow,
    input  etd_pkg::etd_mem_req_s mem_req,
    output logic                  mem_ack,
    output logic [15:0]           mem_rdata
);
    import etd_pkg::*;
    int          writes = 0;
    logic [1:0]  dly = 2'd0;
    logic        seen = 1'b0;
    logic [31:0] first_addr = 32'h0;
    logic [31:0] last_addr = 32'h0;
    logic [31:0] last_data = 32'h0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 16'h0;
    // Idle read data toggles so a stale value never passes for an answer.
    always @(posedge ref_clk)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req.req && !mem_ack && !rst)
        begin
            dly <= dly + 2'd1;
            if (!slow || dly == 2'd3)
            begin
                dly <= 2'd0;
                mem_ack <= 1'b1;
                mem_rdata <= mem_req.addr ^ 16'hA5C3;
                seen <= 1'b1;
                first_addr <= seen ? first_addr : {16'h0, mem_req.addr};
                if (mem_req.wr)
                begin
                    writes <= writes + 1;
                    last_addr <= {16'h0, mem_req.addr};
                    last_data <= {16'h0, mem_req.wdata};
                end
            end
        end
    end
endmodule : etd_mem_model

//--- tb/etd_props.sv
`timescale 1ns/1ps
module etd_props
(
    input wire logic             ref_clk,
    input wire logic             rst,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata,
    input etd_pkg::etd_apb_rsp_s apb_rsp,
    input wire logic [7:0]       act_events,
    input etd_pkg::etd_mem_req_s mem_req,
    input wire logic             mem_ack,
    input wire logic [15:0]      mem_rdata,
    input wire logic             irq
);
    import etd_pkg::*;
    logic [15:0] rd;
    logic        acc;
    assign acc = psel && penable;
    // Last answered read, which the next write must carry.
    always_ff @(posedge ref_clk)
        rd <= (mem_req.req && !mem_req.wr && mem_ack) ? mem_rdata : rd;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_wait; acc && !apb_rsp.pready |=> apb_rsp.pready; endproperty
    a_wait: assert property (p_wait) else $error("apb answer late");
    property p_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready too long");
    property p_inacc; apb_rsp.pready |-> acc && $past(acc); endproperty
    a_inacc: assert property (p_inacc) else $error("pready outside access");
    property p_err; apb_rsp.pready |-> apb_rsp.pslverr == (paddr > OFS_BUSY || paddr[1:0] != 2'b00); endproperty
    a_err: assert property (p_err) else $error("wrong pslverr");
    property p_rdz; apb_rsp.pslverr |-> apb_rsp.prdata == SLV_ERR_DATA; endproperty
    a_rdz: assert property (p_rdz) else $error("error read data not zero");
    property p_hold; mem_req.req && !mem_ack |=> $stable(mem_req); endproperty
    a_hold: assert property (p_hold) else $error("memory request changed");
    property p_wdat; mem_req.req && mem_req.wr |-> ((mem_req.wdata ^ rd) & (mem_req.wide ? 16'hFFFF : 16'h00FF)) == 0;
    endproperty
    a_wdat: assert property (p_wdat) else $error("write data not read data");
    property p_rst; $fell(rst) |-> !mem_req.req && !irq && !apb_rsp.pready; endproperty
    a_rst: assert property (p_rst) else $error("outputs busy after reset");
    property p_irq; $changed(irq) |-> $past(mem_ack) || $past(mem_ack, 2) || $past(acc && pwrite)
        || $past(acc && pwrite, 2); endproperty
    a_irq: assert property (p_irq) else $error("irq moved without cause");
    c_irq: cover property ($rose(irq));
    c_err: cover property (apb_rsp.pslverr);
    c_wide: cover property (mem_req.req && mem_req.wr && mem_req.wide && mem_ack);
endmodule : etd_props
bind etd_channel etd_props u_props (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .apb_rsp(apb_rsp), .act_events(act_events),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq(irq));

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import etd_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0;
    logic [7:0]   act_events = 8'h00;
    logic         slow = 1'b0;
    logic         mem_ack;
    logic [15:0]  mem_rdata;
    logic         irq;
    logic [31:0]  q;
    logic         e;
    int           error_cnt = 0;
    int           samples_checked = 0;
    etd_apb_rsp_s apb_rsp;
    etd_mem_req_s mem_req;
    always #20 ref_clk = ~ref_clk;
    etd_channel dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .apb_rsp(apb_rsp), .act_events(act_events), .mem_req(mem_req),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq(irq));
    etd_mem_model mem (.ref_clk(ref_clk), .rst(rst), .slow(slow), .mem_req(mem_req), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x)
        begin
            error_cnt++;
            $display("BAD %0t seen %h want %h", $time, s, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask : rd
    task automatic cfg(input logic [7:0] c, input logic [7:0] b, input logic [7:0] n);
        apb(1'b1, OFS_CTRL_BASE, 32'hFD);
        apb(1'b1, OFS_SRC_ADDR, 32'h1000);
        apb(1'b1, OFS_DST_ADDR, 32'h2000);
        apb(1'b1, OFS_CONTROL, {24'h0, c});
        apb(1'b1, OFS_BLOCK_SIZE, {24'h0, b});
        apb(1'b1, OFS_COUNT, {24'h0, n});
        apb(1'b1, OFS_RELOAD, {24'h0, n});
    endtask : cfg
    task automatic wait_done();
        apb(1'b0, OFS_ACT_ENABLE, 32'h0);
        while (q !== 32'h0)
            apb(1'b0, OFS_ACT_ENABLE, 32'h0);
        act_events <= 8'h00;
    endtask : wait_done
    task automatic t_regs();
        for (int a = 0; a <= 40; a += 4)
            rd(8'(a), 32'h0);
        for (int a = 0; a < 32; a += 4)
        begin
            apb(1'b1, 8'(a), 32'h1234A57E);
            rd(8'(a), a < 24 ? 32'h7E : 32'hA57E);
            apb(1'b1, 8'(a), 32'h0);
        end
        apb(1'b0, 8'h2C, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, SLV_ERR_DATA);
    endtask : t_regs
    task automatic t_norm();
        slow <= 1'b1;
        act_events <= 8'h04;
        cfg(8'h6C, 8'h02, 8'h01);
        chk(mem.writes, 0);
        apb(1'b1, OFS_IRQ_MASK, 32'h3);
        apb(1'b1, OFS_ACT_ENABLE, 32'h4);
        wait_done();
        chk(mem.first_addr, 32'hFD02);
        chk(mem.writes, 2);
        chk(mem.last_addr, 32'h2002);
        chk(mem.last_data, 32'h1002 ^ 32'hA5C3);
        rd(OFS_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
    endtask : t_norm
    task automatic t_big();
        slow <= 1'b0;
        cfg(8'h00, 8'h00, 8'h02);
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        act_events <= 8'h01;
        apb(1'b1, OFS_ACT_ENABLE, 32'h1);
        wait_done();
        chk(mem.writes, 514);
        chk(mem.last_addr, 32'h2000);
        chk(mem.last_data & 32'hFF, 32'hC3);
        rd(OFS_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
    endtask : t_big
    task automatic t_rpt();
        cfg(8'h2D, 8'h01, 8'h02);
        apb(1'b1, OFS_IRQ_MASK, 32'h2);
        act_events <= 8'h02;
        apb(1'b1, OFS_ACT_ENABLE, 32'h2);
        wait_done();
        chk(mem.writes, 516);
        rd(OFS_COUNT, 32'h2);
        rd(OFS_DST_ADDR, 32'h2000);
        rd(OFS_SRC_ADDR, 32'h1002);
        rd(OFS_IRQ_STATUS, 32'h2);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_STATUS, 32'h2);
    endtask : t_rpt
    task automatic t_rpt_src();
        cfg(8'h0F, 8'h01, 8'h01);
        apb(1'b1, OFS_ACT_ENABLE, 32'h2);
        // A single-cycle event gives exactly one activation.
        act_events <= 8'h02;
        @(posedge ref_clk);
        act_events <= 8'h00;
        apb(1'b0, OFS_BUSY, 32'h0);
        while (q !== 32'h0)
            apb(1'b0, OFS_BUSY, 32'h0);
        chk(mem.writes, 517);
        rd(OFS_SRC_ADDR, 32'h1000);
        rd(OFS_DST_ADDR, 32'h2001);
        rd(OFS_COUNT, 32'h1);
        rd(OFS_IRQ_STATUS, 32'h0);
        rd(OFS_ACT_ENABLE, 32'h2);
        apb(1'b1, OFS_ACT_ENABLE, 32'h0);
    endtask : t_rpt_src
    task automatic wrap_up();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_regs();
        t_norm();
        t_big();
        t_rpt();
        t_rpt_src();
        wrap_up();
    end
    initial
    begin
        #2000000;
        error_cnt++;
        wrap_up();
    end
endmodule : testbench
